//--- core/llt_loop_ctrl.sv
// Layer-1 transceiver enable and test loopback control
`timescale 1ns/10ps
`include "llt_defs.svh"

module llt_loop_ctrl
	import llt_pkg::*;
#(
	parameter int B_W = `LLT_B_W,
	parameter int D_W = `LLT_D_W
) (
	input wire logic i_core_clk, // 100 MHz core clock
	input wire logic i_nrst, // Asynchronous reset, active low
	input wire logic i_ce, // Clock enable, freezes all state when low
	input wire logic i_frame_sync, // Internal frame boundary pulse
	input wire logic i_transmitter_off_bit, // Host: S transmitter off
	input wire logic i_transceiver_off_bit, // Host: whole S layer 1 off
	input wire logic i_analog_wrap_bit, // Host: S analog loop command
	input wire logic i_external_wrap_bit, // Host: S loop is external
	input wire logic i_l1_sm_disable, // Layer-1 state machine disabled
	input wire logic [2:0] i_local_sel, // Local loop channels B1,B2,D
	input wire logic i_local_to_line, // Local loop faces U line when 1
	input wire logic i_local_nontransp, // Local loop non-transparent
	input wire logic i_s_ci_valid, // Command to S transceiver valid
	input wire logic [3:0] i_s_ci_code, // Command code to S transceiver
	input wire logic i_u_ci_valid, // Command to U transceiver valid
	input wire logic [3:0] i_u_ci_code, // Command code to U transceiver
	input wire logic i_u_reset, // U transceiver forced into reset
	input wire logic i_u_transparent, // U transceiver in transparent state
	input wire logic i_eoc_automode, // Maintenance channel auto mode
	input wire logic i_eoc_valid, // Maintenance loop request valid
	input wire llt_eoc_op_e i_eoc_op, // Maintenance loop operation
	input wire logic i_level_seen, // S line level detected
	input wire logic [2*B_W+D_W-1:0] i_u_rx_word, // B1,B2,D from U line
	input wire logic [2*B_W+D_W-1:0] i_s_rx_word, // B1,B2,D from S side
	output logic [2*B_W+D_W-1:0] o_u_tx_word, // B1,B2,D to U line
	output logic [2*B_W+D_W-1:0] o_s_tx_word, // B1,B2,D toward S side
	output logic o_s_tx_en, // S transmit buffers enabled
	output logic o_s_rx_en, // S receiver running
	output logic o_level_det_en, // S level detector enabled
	output logic o_s_pwr_min, // S transceiver at minimum power
	output logic o_s_loop_int, // Internal S loop closed
	output logic o_s_loop_ext, // External S loop closed
	output logic o_u_loop3, // U analog loop closed
	output logic [2:0] o_lb2_state, // Latched loop-2 channels B1,B2,D
	output logic o_ci_dn_valid, // Code to downstream, one cycle
	output logic [3:0] o_ci_dn_code, // Code to downstream
	output logic o_ci_up_valid, // Indication from S side, one cycle
	output logic [3:0] o_ci_up_code // Indication code from S side
);

	localparam int W = 2*B_W+D_W;

	if (B_W < 1 || D_W < 1) begin : g_chk
		$error("llt_loop_ctrl: channel widths must be at least one bit");
	end

	// Expand a three-bit channel selection into a data mask
	function automatic logic [W-1:0] chan_mask(input logic [2:0] sel);
		return {{B_W{sel[`LLT_SEL_B1]}}, {B_W{sel[`LLT_SEL_B2]}},
			{D_W{sel[`LLT_SEL_D]}}};
	endfunction

	// Configuration stage, loaded only at frame boundaries, followed by loop state updated every enabled cycle
	logic txoff_r;
	logic trxoff_r;
	logic awrap_r;
	logic exwrap_r;
	logic [2:0] lsel_r;
	logic lline_r;
	logic lntr_r;
	logic cmd_loop_r;
	logic level_d_r;
	logic [2:0] lb2_r;
	llt_u_state_e ust_r;
	llt_u_state_e ust_nxt;

	// Frame-aligned updates avoid tearing a half-sent frame
	wire cfg_load = i_ce & i_frame_sync;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			txoff_r <= `LLT_TXOFF_RST;
			trxoff_r <= `LLT_TRXOFF_RST;
			awrap_r <= 1'b0;
			exwrap_r <= 1'b0;
			lsel_r <= 3'h0;
			lline_r <= 1'b0;
			lntr_r <= `LLT_NONTRANSP_RST;
		end else if (cfg_load) begin
			txoff_r <= i_transmitter_off_bit;
			trxoff_r <= i_transceiver_off_bit;
			awrap_r <= i_analog_wrap_bit;
			exwrap_r <= i_external_wrap_bit;
			lsel_r <= i_local_sel;
			lline_r <= i_local_to_line;
			lntr_r <= i_local_nontransp;
		end
	end

	// S-side command loop: set by loop request, any other command opens
	wire s_lreq = i_s_ci_valid & (i_s_ci_code == `LLT_CI_LREQ);
	wire cmd_loop_nxt = i_s_ci_valid ? s_lreq : cmd_loop_r;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmd_loop_r <= 1'b0;
		end else if (i_ce) begin
			cmd_loop_r <= cmd_loop_nxt;
		end
	end

	// Wrap bit counts only while the layer-1 state machine is off
	wire s_loop = ~trxoff_r &
		(cmd_loop_r | (i_l1_sm_disable & awrap_r));
	wire s_int = s_loop & ~exwrap_r;
	wire s_ext = s_loop & exwrap_r;

	// U transceiver analog loop state
	wire u_lreq = i_u_ci_valid & (i_u_ci_code == `LLT_CI_LREQ);

	always_comb begin
		ust_nxt = ust_r;
		case (ust_r)
			LLT_U_RUN: begin
				if (i_u_reset) begin
					ust_nxt = LLT_U_RESET;
				end else if (u_lreq) begin
					ust_nxt = LLT_U_LOOP3;
				end
			end
			LLT_U_RESET: begin
				// Loop request is only honoured once reset is released
				if (!i_u_reset && u_lreq) begin
					ust_nxt = LLT_U_LOOP3;
				end else if (!i_u_reset) begin
					ust_nxt = LLT_U_RUN;
				end
			end
			LLT_U_LOOP3: begin
				if (i_u_reset) begin
					ust_nxt = LLT_U_RESET;
				end
			end
			default: ust_nxt = LLT_U_RESET;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ust_r <= LLT_U_RUN;
		end else if (i_ce) begin
			ust_r <= ust_nxt;
		end
	end

	wire loop3 = (ust_r == LLT_U_LOOP3);

	// Loop 2: latched per channel, no reset, line stays up
	wire eoc_all = i_eoc_valid & (i_eoc_op == LLT_EOC_CLOSE_ALL);
	wire auto_fwd = eoc_all & i_eoc_automode;
	logic [2:0] lb2_nxt;

	always_comb begin
		lb2_nxt = lb2_r;
		if (i_eoc_valid) begin
			case (i_eoc_op)
				LLT_EOC_CLOSE_ALL: begin
					if (!i_eoc_automode) begin
						lb2_nxt = 3'h7;
					end
				end
				LLT_EOC_CLOSE_B1: lb2_nxt[`LLT_SEL_B1] = 1'b1;
				LLT_EOC_CLOSE_B2: lb2_nxt[`LLT_SEL_B2] = 1'b1;
				LLT_EOC_OPEN_ALL: lb2_nxt = 3'h0;
				LLT_EOC_OPEN_B1: lb2_nxt[`LLT_SEL_B1] = 1'b0;
				LLT_EOC_OPEN_B2: lb2_nxt[`LLT_SEL_B2] = 1'b0;
				default: lb2_nxt = lb2_r;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lb2_r <= 3'h0;
		end else if (i_ce) begin
			lb2_r <= lb2_nxt;
		end
	end

	// Data path selection
	wire [W-1:0] ones = {W{1'b1}};
	wire [W-1:0] mask_lb2 = chan_mask(lb2_r);
	wire [W-1:0] mask_lu = chan_mask(lline_r ? lsel_r : 3'h0);
	wire [W-1:0] mask_lb = chan_mask(lline_r ? 3'h0 : lsel_r);
	wire [W-1:0] mask_u = mask_lb2 | mask_lu;
	// Upstream source: S loop returns U line input, S pins are ignored
	wire [W-1:0] up_src = s_loop ? i_u_rx_word : i_s_rx_word;
	// Loop 3 takes the pre-loop upstream word, ignoring the line
	wire [W-1:0] u_rx_eff = loop3 ? up_src : i_u_rx_word;
	wire [W-1:0] up_loop = (u_rx_eff & mask_u) | (up_src & ~mask_u);
	wire [W-1:0] lb_kill = lntr_r ? mask_lb : '0;
	wire [W-1:0] lu_kill = lntr_r ? mask_lu : '0;
	wire [W-1:0] up_nxt = (up_loop & ~lb_kill) | (ones & lb_kill);
	wire [W-1:0] dn_loop = (i_s_rx_word & mask_lb) | (u_rx_eff & ~mask_lb);
	// Standard loops stay transparent: the looped data still goes on
	wire [W-1:0] dn_nxt = (dn_loop & ~lu_kill) | (ones & lu_kill);

	// Enables
	wire tx_en_nxt = ~trxoff_r & ~txoff_r;
	wire rx_en_nxt = ~trxoff_r;
	wire lvl_en_nxt = ~trxoff_r & ~s_ext;

	// Resync on a fresh level while the internal loop stays closed
	wire resync_fire = s_int & i_level_seen & ~level_d_r;

	// One register stage on every path keeps loop latency equal
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_u_tx_word <= '1;
			o_s_tx_word <= '1;
		end else if (i_ce) begin
			o_u_tx_word <= up_nxt;
			o_s_tx_word <= dn_nxt;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_s_tx_en <= 1'b0;
			o_s_rx_en <= 1'b0;
			o_level_det_en <= 1'b0;
			o_s_pwr_min <= 1'b1;
		end else if (i_ce) begin
			o_s_tx_en <= tx_en_nxt;
			o_s_rx_en <= rx_en_nxt;
			o_level_det_en <= lvl_en_nxt;
			o_s_pwr_min <= trxoff_r;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_s_loop_int <= 1'b0;
			o_s_loop_ext <= 1'b0;
			o_u_loop3 <= 1'b0;
			o_lb2_state <= 3'h0;
			level_d_r <= 1'b0;
		end else if (i_ce) begin
			o_s_loop_int <= s_int;
			o_s_loop_ext <= s_ext;
			o_u_loop3 <= (ust_nxt == LLT_U_LOOP3);
			o_lb2_state <= lb2_nxt;
			level_d_r <= i_level_seen;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ci_dn_valid <= 1'b0;
			o_ci_dn_code <= 4'h0;
			o_ci_up_valid <= 1'b0;
			o_ci_up_code <= 4'h0;
		end else if (i_ce) begin
			o_ci_dn_valid <= auto_fwd;
			if (auto_fwd) begin
				o_ci_dn_code <= i_u_transparent ?
					`LLT_CI_LIND : `LLT_CI_LREQ;
			end
			o_ci_up_valid <= resync_fire;
			if (resync_fire) begin
				o_ci_up_code <= `LLT_CI_RESYNC;
			end
		end
	end

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_close_b1;
		i_ce && i_eoc_valid && i_eoc_op == LLT_EOC_CLOSE_B1;
	endsequence
	sequence s_close_b2;
		i_ce && i_eoc_valid && i_eoc_op == LLT_EOC_CLOSE_B2;
	endsequence
	sequence s_auto_req;
		i_ce && i_eoc_valid && i_eoc_op == LLT_EOC_CLOSE_ALL &&
			i_eoc_automode;
	endsequence
	sequence s_loop3_req;
		i_ce && u_lreq && !i_u_reset;
	endsequence
	AST_TX_OFF: assert property (
		(i_ce && txoff_r) |=> !o_s_tx_en)
		else $error("transmitter on while transmitter-off bit set");
	AST_RX_ON: assert property (
		(i_ce && !trxoff_r && txoff_r) |=> (o_s_rx_en && !o_s_tx_en))
		else $error("receiver stopped with only transmitter off");
	AST_RST_TXOFF: assert property (
		!$past(i_nrst) |-> txoff_r)
		else $error("transmitter-off bit not set after reset");
	AST_TRX_OFF: assert property (
		(i_ce && trxoff_r) |=>
			(o_s_pwr_min && !o_level_det_en && !o_s_tx_en && !o_s_rx_en))
		else $error("layer 1 still active with transceiver off");
	AST_LB2_BOTH: assert property (
		(s_close_b1 ##1 s_close_b2) |=>
			(o_lb2_state[`LLT_SEL_B1] && o_lb2_state[`LLT_SEL_B2]))
		else $error("B1 and B2 loops not held together");
	AST_AUTO_CODE: assert property (
		s_auto_req |=> (o_ci_dn_valid && o_ci_dn_code ==
			($past(i_u_transparent) ? `LLT_CI_LIND : `LLT_CI_LREQ)))
		else $error("wrong complete-loop code forwarded");
	AST_LOOP3_CLOSE: assert property (
		s_loop3_req |=> o_u_loop3 ##1 (o_u_loop3 || $past(i_u_reset)))
		else $error("loop 3 did not close on request");
	AST_RESYNC: assert property (
		(i_ce && resync_fire) |=> (o_ci_up_valid && o_s_loop_int &&
			o_ci_up_code == `LLT_CI_RESYNC))
		else $error("level in internal loop gave no resync");
	AST_FRAME_HOLD: assert property (
		!(i_ce && i_frame_sync) |=> ($stable(txoff_r) && $stable(lsel_r)))
		else $error("configuration changed off a frame boundary");
	AST_EXT_LVL: assert property (
		(i_ce && s_ext) |=> !o_level_det_en)
		else $error("level detector on during external loop");
	AST_LB2_FWD: assert property (
		(i_ce && !loop3 && mask_lb == '0 && lu_kill == '0) |=>
			o_s_tx_word == $past(i_u_rx_word))
		else $error("downstream data not forwarded");
	AST_NONTR: assert property (
		(i_ce && lntr_r && lline_r && lsel_r == 3'h7) |=>
			o_s_tx_word == ones)
		else $error("non-transparent local loop not idle");

endmodule

//--- core/llt_defs.svh
// Constants for the layer-1 loopback and transmit-enable control
`ifndef LLT_DEFS_SVH
`define LLT_DEFS_SVH

// Command/indication codes
`define LLT_CI_LREQ 4'ha
`define LLT_CI_LIND 4'he
`define LLT_CI_RESYNC 4'h4

// Reset values of the configuration stage
`define LLT_TXOFF_RST 1'b1
`define LLT_TRXOFF_RST 1'b0
`define LLT_NONTRANSP_RST 1'b0

// Channel select bit positions within a three-bit channel mask
`define LLT_SEL_B1 2
`define LLT_SEL_B2 1
`define LLT_SEL_D 0

// Default channel widths
`define LLT_B_W 8
`define LLT_D_W 2

`endif

//--- core/llt_pkg.sv
// Types shared by the layer-1 loopback and transmit-enable control
package llt_pkg;

	// Maintenance-channel loop operations from the exchange
	typedef enum logic [2:0] {
		LLT_EOC_CLOSE_ALL,
		LLT_EOC_CLOSE_B1,
		LLT_EOC_CLOSE_B2,
		LLT_EOC_OPEN_ALL,
		LLT_EOC_OPEN_B1,
		LLT_EOC_OPEN_B2
	} llt_eoc_op_e;

	// U transceiver loop state
	typedef enum logic [1:0] {
		LLT_U_RUN,
		LLT_U_RESET,
		LLT_U_LOOP3
	} llt_u_state_e;

endpackage

//--- bench/llt_far_end.sv
// Exchange and S-bus partner model for the loop control
`timescale 1ns/10ps
`include "llt_defs.svh"
module llt_far_end (
	input wire logic i_clk, // Core clock
	output logic o_u_ci_valid, // Command to U side valid
	output logic [3:0] o_u_ci_code, // Command code to U side
	output logic o_u_reset, // U transceiver reset
	output logic o_level // S line level seen
);
	initial begin
		o_u_ci_valid = 1'h0;
		o_u_ci_code = 4'h0;
		o_u_reset = 1'h0;
		o_level = 1'h0;
	end
	// Reset first, stale echo coefficients would spoil the loop
	task close3();
		@(posedge i_clk) o_u_reset <= 1'h1;
		@(posedge i_clk) o_u_reset <= 1'h0;
		@(posedge i_clk) begin
			o_u_ci_valid <= 1'h1;
			o_u_ci_code <= `LLT_CI_LREQ;
		end
		@(posedge i_clk) o_u_ci_valid <= 1'h0;
	endtask
	task open3();
		@(posedge i_clk) o_u_reset <= 1'h1;
		@(posedge i_clk) o_u_reset <= 1'h0;
	endtask
	task level(input logic v);
		@(posedge i_clk) o_level <= v;
	endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the loop control block
`timescale 1ns/10ps
`include "llt_defs.svh"
module tb_top;
	import llt_pkg::*;
	localparam int W = 2*`LLT_B_W+`LLT_D_W;
	logic clk = 1'h0, nrst = 1'h0, fs = 1'h0, txo = 1'h1, trxo = 1'h0;
	logic awrap = 1'h0, ewrap = 1'h0, smd = 1'h0, lline = 1'h0;
	logic lnt = 1'h0, sv = 1'h0, utr = 1'h0, am = 1'h0, ev = 1'h0, ce = 1'h1;
	logic [2:0] lsel = 3'h0;
	logic [3:0] sc = 4'h0;
	llt_eoc_op_e eop = LLT_EOC_OPEN_ALL;
	logic [W-1:0] urx = '0, srx = '0;
	logic [31:0] rnd = 32'h7;
	logic uval, ureset, lvl, txen, rxen, det, pmin, li, le, l3, dnv, upv;
	logic [3:0] uc, dnc, upc;
	logic [2:0] lb2;
	logic [W-1:0] utx, stx;
	int num_errors = 0, compares = 0;
	wire [3:0] en = {txen, rxen, det, pmin};
	wire [3:0] lp = {li, le, det, l3};

	llt_loop_ctrl dut (
		.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_frame_sync(fs),
		.i_transmitter_off_bit(txo), .i_transceiver_off_bit(trxo),
		.i_analog_wrap_bit(awrap), .i_external_wrap_bit(ewrap),
		.i_l1_sm_disable(smd), .i_local_sel(lsel), .i_local_to_line(lline),
		.i_local_nontransp(lnt), .i_s_ci_valid(sv), .i_s_ci_code(sc),
		.i_u_ci_valid(uval), .i_u_ci_code(uc), .i_u_reset(ureset),
		.i_u_transparent(utr), .i_eoc_automode(am), .i_eoc_valid(ev),
		.i_eoc_op(eop), .i_level_seen(lvl), .i_u_rx_word(urx),
		.i_s_rx_word(srx), .o_u_tx_word(utx), .o_s_tx_word(stx),
		.o_s_tx_en(txen), .o_s_rx_en(rxen), .o_level_det_en(det),
		.o_s_pwr_min(pmin), .o_s_loop_int(li), .o_s_loop_ext(le),
		.o_u_loop3(l3), .o_lb2_state(lb2), .o_ci_dn_valid(dnv),
		.o_ci_dn_code(dnc), .o_ci_up_valid(upv), .o_ci_up_code(upc)
	);
	llt_far_end p (
		.i_clk(clk), .o_u_ci_valid(uval), .o_u_ci_code(uc),
		.o_u_reset(ureset), .o_level(lvl)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Channel mask {B1,B2,D} widened to a word
	function automatic logic [W-1:0] m(input logic [2:0] c);
		return {{`LLT_B_W{c[2]}}, {`LLT_B_W{c[1]}}, {`LLT_D_W{c[0]}}};
	endfunction

	task end_of_test();
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chkw(input string n, input logic [W-1:0] e, g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task chkf(input string n, input logic [3:0] e, g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// lu/ls: channels looped back, ou/os: channels forced to ones
	task data(input logic [2:0] lu, ls, ou, os);
		logic [W-1:0] u, s;
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			u = rnd[W-1:0];
			rnd = lfsr(rnd);
			s = rnd[W-1:0];
			@(posedge clk);
			urx <= u;
			srx <= s;
			@(posedge clk);
			#1;
			chkw("u word", (u & m(lu)) | (s & ~m(lu)) | m(ou), utx);
			chkw("s word", (s & m(ls)) | (u & ~m(ls)) | m(os), stx);
		end
	endtask
	task frame(input logic t, r, e, input logic [2:0] sel, input logic l, n);
		@(posedge clk) begin
			fs <= 1'h1;
			txo <= t;
			trxo <= r;
			ewrap <= e;
			lsel <= sel;
			lline <= l;
			lnt <= n;
		end
		@(posedge clk) fs <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task eoc(input llt_eoc_op_e op);
		@(posedge clk) begin
			ev <= 1'h1;
			eop <= op;
		end
		@(posedge clk) ev <= 1'h0;
		#1;
	endtask
	task scmd(input logic [3:0] c);
		@(posedge clk) begin
			sv <= 1'h1;
			sc <= c;
		end
		@(posedge clk) sv <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial begin
		#20000;
		num_errors++;
		end_of_test();
	end

	initial begin
		repeat (11) @(posedge clk);
		#1;
		chkf("reset enables", 4'h1, en);
		@(posedge clk) nrst <= 1'h1;
		repeat (2) @(posedge clk);
		#1;
		chkf("enables", 4'h6, en);
		// Frame strobe while frozen must not load the new bits
		@(posedge clk) begin
			ce <= 1'h0;
			fs <= 1'h1;
			txo <= 1'h0;
		end
		repeat (3) @(posedge clk);
		#1;
		chkf("frozen", 4'h6, en);
		@(posedge clk) begin
			ce <= 1'h1;
			fs <= 1'h0;
		end
		frame(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		chkf("enables", 4'he, en);
		@(posedge clk) txo <= 1'h1;
		repeat (4) @(posedge clk);
		#1;
		chkf("enables", 4'he, en);
		frame(1'h1, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		chkf("enables", 4'h6, en);
		frame(1'h0, 1'h1, 1'h0, 3'h0, 1'h0, 1'h0);
		chkf("enables", 4'h1, en);
		frame(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		data(3'h0, 3'h0, 3'h0, 3'h0);
		frame(1'h0, 1'h0, 1'h0, 3'h7, 1'h1, 1'h1);
		data(3'h7, 3'h0, 3'h0, 3'h7);
		frame(1'h0, 1'h0, 1'h0, 3'h4, 1'h1, 1'h0);
		data(3'h4, 3'h0, 3'h0, 3'h0);
		frame(1'h0, 1'h0, 1'h0, 3'h3, 1'h0, 1'h1);
		data(3'h0, 3'h3, 3'h3, 3'h0);
		frame(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		eoc(LLT_EOC_CLOSE_B1);
		chkf("loop2", 4'h4, 4'(lb2));
		eoc(LLT_EOC_CLOSE_B2);
		chkf("loop2", 4'h6, 4'(lb2));
		data(3'h6, 3'h0, 3'h0, 3'h0);
		chkf("enables", 4'he, en);
		eoc(LLT_EOC_OPEN_B1);
		chkf("loop2", 4'h2, 4'(lb2));
		eoc(LLT_EOC_OPEN_B2);
		chkf("loop2", 4'h0, 4'(lb2));
		eoc(LLT_EOC_CLOSE_ALL);
		chkf("loop2", 4'h7, 4'(lb2));
		eoc(LLT_EOC_OPEN_ALL);
		chkf("loop2", 4'h0, 4'(lb2));
		// Back-to-back B1 then B2 requests, both must latch
		@(posedge clk) begin
			ev <= 1'h1;
			eop <= LLT_EOC_CLOSE_B1;
		end
		@(posedge clk) eop <= LLT_EOC_CLOSE_B2;
		@(posedge clk) ev <= 1'h0;
		#1;
		chkf("loop2", 4'h6, 4'(lb2));
		eoc(LLT_EOC_OPEN_ALL);
		chkf("loop2", 4'h0, 4'(lb2));
		for (int t = 0; t < 2; t++) begin
			@(posedge clk) begin
				am <= 1'h1;
				utr <= t[0];
			end
			eoc(LLT_EOC_CLOSE_ALL);
			chkf("down code", t ? `LLT_CI_LIND : `LLT_CI_LREQ, dnc);
			chkf("down pulse", 4'h1, 4'(dnv));
		end
		am <= 1'h0;
		scmd(`LLT_CI_LREQ);
		chkf("s loop", 4'ha, lp);
		data(3'h7, 3'h0, 3'h0, 3'h0);
		p.level(1'h1);
		for (int i = 0; i < 3 && upv !== 1'h1; i++) begin
			@(posedge clk);
			#1;
		end
		chkf("resync", `LLT_CI_RESYNC, upc);
		chkf("resync pulse", 4'h1, 4'(upv));
		chkf("s loop", 4'ha, lp);
		p.level(1'h0);
		frame(1'h1, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		chkf("enables", 4'h6, en);
		scmd(4'h0);
		frame(1'h1, 1'h0, 1'h1, 3'h0, 1'h0, 1'h0);
		scmd(`LLT_CI_LREQ);
		chkf("ext loop", 4'h2, {2'h0, le, det});
		scmd(4'h0);
		chkf("s loop", 4'h0, {li, le, 1'h0, l3});
		frame(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		@(posedge clk) begin
			smd <= 1'h1;
			awrap <= 1'h1;
		end
		// Wrap bit is part of the frame-loaded configuration
		frame(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 1'h0);
		chkf("wrap loop", 4'h8, {li, le, 1'h0, l3});
		@(posedge clk) begin
			smd <= 1'h0;
			awrap <= 1'h0;
		end
		scmd(4'h0);
		p.close3();
		#1;
		chkf("loop3", 4'h1, 4'(l3));
		data(3'h0, 3'h7, 3'h0, 3'h0);
		p.open3();
		repeat (2) @(posedge clk);
		#1;
		chkf("loop3", 4'h0, 4'(l3));
		end_of_test();
	end
endmodule
